// *** ddrsp_port.sv ***
// bus port of a common-i/o ddr sram with two-beat bursts and apb control
// What this block does
// R1: the address is taken into a register at a true-clock edge of a load.
// R2: while no load is signalled the address inputs start nothing.
// R3: a low load strobe starts a sequence and latches address and direction.
// R4: with the load low, read/write select high means read, low means write.
// R5: a write beat stores only the bytes whose byte-write enable is low.
// R6: each byte-write enable is sampled in the same half-cycle as its data beat.
// R7: address and control are taken on true edges, write data on both edges.
// R8: the controller supplies the complementary clock as the inverse of the true clock.
// R9: a low pll bypass bit makes the port run straight from the input clocks.
// R10: a low termination range bit selects the low range, 0.3 of the reference.
// R11: a high termination range bit selects the high range, 0.6 of the reference.
// R12: an impedance reference tied to the supply selects minimum output impedance.
// R13: only data lines 0 to 17 are used; lines 18 to 35 stay idle.
// R14: read valid rises half a cycle before the first beat and falls half before the end.
// R15: the echo clocks toggle every half-cycle, also while the bus is idle.
// R16: termination is on while receiving and off while read data is driven.
// R17: every access is a two-beat burst; read data starts 2.5 cycles after the load.
`timescale 1ns/1ps
`default_nettype none
module ddrsp_port (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ddrsp_pkg::APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [ddrsp_pkg::ADDR_W-1:0] addr_in_i,
   input wire logic cycle_load_n_i,
   input wire logic rw_sel_i,
   input wire logic [ddrsp_pkg::BE_W-1:0] byte_write_en_n_i,
   input wire logic [ddrsp_pkg::BUS_W-1:0] dq_i,
   output logic [ddrsp_pkg::BUS_W-1:0] dq_o,
   output logic [ddrsp_pkg::BUS_W-1:0] dq_oe_o,
   input wire logic dq_ready_i,
   output logic cmd_ready_o,
   output logic read_valid_out_o,
   output logic echo_clk_o,
   output logic echo_clk_n_o,
   output logic odt_en_o,
   output logic term_range_o,
   output logic min_imp_o,
   output logic pll_bypass_o
);
   import ddrsp_pkg::*;

   ddrsp_state_t state_ff, nxt_state;
   logic [2:0] cnt_ff, nxt_cnt;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic phase_ff, nxt_phase;
   logic [2:0] ctrl_ff, nxt_ctrl;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pslverr_ff, nxt_pslverr;
   logic [DATA_W-1:0] fifo_mem_ff [FIFO_DEPTH];
   logic [DATA_W-1:0] nxt_fifo_mem [FIFO_DEPTH];
   logic fifo_wp_ff, nxt_fifo_wp, fifo_rp_ff, nxt_fifo_rp;
   logic [1:0] fifo_cnt_ff, nxt_fifo_cnt;
   logic [DATA_W-1:0] mem [2**MEM_AW];
   logic load_ok, wr_beat, rd_beat, fifo_valid, fifo_in_rdy, push, pop;
   logic [MEM_AW-1:0] waddr, raddr;

   // half-cycle phase: 0 marks a true-clock rising edge, 1 the complement edge
   always_comb begin
      nxt_phase = ~phase_ff; // R15
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         phase_ff <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // loads are taken only on a true edge with the output buffer drained,
   // which keeps the bus turned round and the buffer from overrunning
   assign cmd_ready_o = (state_ff == ST_IDLE) && !phase_ff && (fifo_cnt_ff == 2'h0); // R7
   assign load_ok = cmd_ready_o && !cycle_load_n_i; // R2

   // burst sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_addr = addr_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (load_ok) begin
               nxt_addr = addr_in_i; // R1 R3
               nxt_state = rw_sel_i ? ST_READ : ST_WRITE; // R4
               nxt_cnt = CNT_START;
            end
         end
         ST_WRITE: begin
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == CNT_WR_B1) begin
               nxt_state = ST_IDLE;
               nxt_cnt = 3'h0;
            end
         end
         ST_READ: begin
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == CNT_RD_B1) begin
               nxt_state = ST_IDLE;
               nxt_cnt = 3'h0;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_cnt = 3'h0;
         end
      endcase
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_ff <= ST_IDLE;
         cnt_ff <= 3'h0;
         addr_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         addr_ff <= nxt_addr;
      end
   end

   // two beats per burst; beat 0 on a true edge, beat 1 on the complement edge
   assign wr_beat = (state_ff == ST_WRITE) && ((cnt_ff == CNT_WR_B0) || (cnt_ff == CNT_WR_B1)); // R7 R17
   assign rd_beat = (state_ff == ST_READ) && ((cnt_ff == CNT_RD_B0) || (cnt_ff == CNT_RD_B1)); // R17
   assign waddr = {addr_ff, cnt_ff == CNT_WR_B1};
   assign raddr = {addr_ff, cnt_ff == CNT_RD_B1};

   // storage array; no reset, contents are undefined until written
   always_ff @(posedge core_clk_i) begin
      if (wr_beat) begin
         for (int i = 0; i < BE_W; i++) begin
            if (!byte_write_en_n_i[i]) begin // R5 R6
               mem[waddr][i*BYTE_W +: BYTE_W] <= dq_i[i*BYTE_W +: BYTE_W]; // R13
            end
         end
      end
   end

   // two-entry output buffer; a stalled receiver holds the beats here
   assign fifo_valid = (fifo_cnt_ff != 2'h0);
   assign fifo_in_rdy = (fifo_cnt_ff != 2'(FIFO_DEPTH));
   assign push = rd_beat && fifo_in_rdy;
   assign pop = fifo_valid && dq_ready_i;
   always_comb begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         nxt_fifo_mem[i] = fifo_mem_ff[i];
      end
      nxt_fifo_wp = fifo_wp_ff;
      nxt_fifo_rp = fifo_rp_ff;
      nxt_fifo_cnt = fifo_cnt_ff;
      if (push) begin
         nxt_fifo_mem[fifo_wp_ff] = mem[raddr];
         nxt_fifo_wp = ~fifo_wp_ff;
      end
      if (pop) begin
         nxt_fifo_rp = ~fifo_rp_ff;
      end
      if (push && !pop) begin
         nxt_fifo_cnt = fifo_cnt_ff + 2'h1;
      end else if (pop && !push) begin
         nxt_fifo_cnt = fifo_cnt_ff - 2'h1;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            fifo_mem_ff[i] <= '0;
         end
         fifo_wp_ff <= 1'b0;
         fifo_rp_ff <= 1'b0;
         fifo_cnt_ff <= 2'h0;
      end else begin
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            fifo_mem_ff[i] <= nxt_fifo_mem[i];
         end
         fifo_wp_ff <= nxt_fifo_wp;
         fifo_rp_ff <= nxt_fifo_rp;
         fifo_cnt_ff <= nxt_fifo_cnt;
      end
   end

   // pin side; upper half of the bus is never driven
   assign dq_o = {{(BUS_W-DATA_W){1'b0}}, fifo_mem_ff[fifo_rp_ff]}; // R13
   assign dq_oe_o = {{(BUS_W-DATA_W){1'b0}}, {DATA_W{fifo_valid}}}; // R13
   assign odt_en_o = !fifo_valid; // R16
   // valid leads the buffered beats by the one register stage of the buffer
   assign read_valid_out_o = rd_beat; // R14
   assign echo_clk_o = !phase_ff; // R15
   assign echo_clk_n_o = phase_ff; // R15

   // apb slave: read data and error decided in setup, zero wait states
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_prdata = prdata_ff;
      nxt_pslverr = pslverr_ff;
      if (psel_i && penable_i && pwrite_i && (paddr_i == OFF_CTRL)) begin
         nxt_ctrl = pwdata_i[2:0];
      end
      if (psel_i && !penable_i) begin
         nxt_prdata = 32'h0000_0000;
         nxt_pslverr = 1'b0;
         if (paddr_i == OFF_CTRL) begin
            nxt_prdata[2:0] = ctrl_ff;
         end else if (paddr_i == OFF_STAT) begin
            nxt_pslverr = pwrite_i; // status is read only
            nxt_prdata[STAT_CNT +: 2] = fifo_cnt_ff;
            nxt_prdata[STAT_BUSY] = (state_ff != ST_IDLE);
            nxt_prdata[STAT_ODT] = odt_en_o;
         end else begin
            nxt_pslverr = 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ctrl_ff <= CTRL_RST;
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         prdata_ff <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
      end
   end
   assign prdata_o = prdata_ff;
   assign pslverr_o = pslverr_ff;
   assign pready_o = 1'b1;

   // analog mode selects leave the block as levels for the pad logic
   assign pll_bypass_o = !ctrl_ff[CTRL_PLL_N]; // R9
   assign term_range_o = ctrl_ff[CTRL_TERM]; // R10 R11
   assign min_imp_o = ctrl_ff[CTRL_MINZ]; // R12

   // checks
   a_load_addr_taken: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R1 R3
      load_ok |=> (addr_ff == $past(addr_in_i)) && (state_ff != ST_IDLE))
      else $error("address not latched at load");
   a_idle_ignores_addr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R2
      (state_ff == ST_IDLE && cycle_load_n_i) |=> (state_ff == ST_IDLE) && $stable(addr_ff))
      else $error("access started without load");
   a_dir_from_select: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
      load_ok |=> (state_ff == ($past(rw_sel_i) ? ST_READ : ST_WRITE)))
      else $error("wrong access direction");
   a_byte_stored: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R5 R6
      (wr_beat && !byte_write_en_n_i[0]) |=> mem[$past(waddr)][BYTE_W-1:0] == $past(dq_i[BYTE_W-1:0]))
      else $error("enabled byte not stored");
   a_byte_masked: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R5
      (wr_beat && byte_write_en_n_i[1]) |=> mem[$past(waddr)][DATA_W-1:BYTE_W]
         == $past(mem[waddr][DATA_W-1:BYTE_W]))
      else $error("masked byte changed");
   a_write_beats_edges: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R7 R17
      (load_ok && !rw_sel_i) |-> ##2 (wr_beat && !phase_ff) ##1 (wr_beat && phase_ff) ##1 !wr_beat)
      else $error("write beats misplaced");
   a_read_latency: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R17
      (load_ok && rw_sel_i) |-> ##5 dq_oe_o[0])
      else $error("read data not out 2.5 cycles after load");
   a_qvalid_window: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R14
      (load_ok && rw_sel_i) |-> ##3 !read_valid_out_o ##1 read_valid_out_o [*2] ##1 !read_valid_out_o)
      else $error("read valid window wrong");
   a_echo_toggles: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R15
      $past(rst_n_i) |-> (echo_clk_o != $past(echo_clk_o)) && (echo_clk_n_o == !echo_clk_o))
      else $error("echo clock stopped");
   a_odt_off_driving: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R16
      dq_oe_o[0] |-> !odt_en_o)
      else $error("termination on while driving");
   a_upper_lines_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R13
      dq_oe_o[BUS_W-1:DATA_W] == '0)
      else $error("unused data lines driven");
   a_buffer_no_loss: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R17
      rd_beat |-> fifo_in_rdy)
      else $error("read beat dropped");
endmodule
`default_nettype wire

// *** ddrsp_pkg.sv ***
// constants and types shared by the double-data-rate sram bus port
package ddrsp_pkg;
   localparam int unsigned DATA_W = 18;
   localparam int unsigned BUS_W = 36;
   localparam int unsigned BYTE_W = 9;
   localparam int unsigned BE_W = 2;
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned MEM_AW = ADDR_W + 1;
   localparam int unsigned FIFO_DEPTH = 2;
   // core clock runs at 200 MHz; one core cycle is one half of the true clock
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned K_PERIOD_NS = 10;
   localparam int unsigned HALF_PER_K = K_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned RD_LAT_TENTHS = 25;
   localparam int unsigned RD_LAT_HALF = RD_LAT_TENTHS * HALF_PER_K / 10;
   // half-cycle counter values after a load (load cycle is count 0)
   localparam logic [2:0] CNT_START = 3'h1;
   localparam logic [2:0] CNT_WR_B0 = 3'h2;
   localparam logic [2:0] CNT_WR_B1 = 3'h3;
   localparam logic [2:0] CNT_RD_B0 = 3'(RD_LAT_HALF - 1);
   localparam logic [2:0] CNT_RD_B1 = 3'(RD_LAT_HALF);
   // apb map
   localparam int unsigned APB_AW = 12;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_STAT = 12'h004;
   localparam int unsigned CTRL_PLL_N = 0;
   localparam int unsigned CTRL_TERM = 1;
   localparam int unsigned CTRL_MINZ = 2;
   localparam logic [2:0] CTRL_RST = 3'h3;
   localparam int unsigned STAT_CNT = 0;
   localparam int unsigned STAT_BUSY = 2;
   localparam int unsigned STAT_ODT = 3;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WRITE = 2'b01,
      ST_READ = 2'b10
   } ddrsp_state_t;
endpackage

// *** ddrsp_ctl_model.sv ***
// memory controller model on the sram bus side of the port
`timescale 1ns/1ps
`default_nettype none
module ddrsp_ctl_model (
   input wire logic core_clk_i,
   input wire logic cmd_ready_i,
   input wire logic [ddrsp_pkg::BUS_W-1:0] q_i,
   input wire logic [ddrsp_pkg::BUS_W-1:0] q_oe_i,
   input wire logic read_valid_i,
   output logic [ddrsp_pkg::ADDR_W-1:0] addr_o,
   output logic load_n_o,
   output logic rw_o,
   output logic [ddrsp_pkg::BE_W-1:0] be_n_o,
   output logic [ddrsp_pkg::BUS_W-1:0] d_o,
   output logic ready_o
);
   import ddrsp_pkg::*;
   int cyc = 0;
   initial {addr_o, load_n_o, rw_o, be_n_o, d_o, ready_o} = {10'h0, 1'b1, 1'b0, 2'h3, 36'h0, 1'b1};
   // cycle count, read just after a rising edge, before it steps on
   always @(posedge core_clk_i) cyc <= cyc + 1;
   // hold the load until the rising edge that samples the port ready; then scramble the released lines
   task automatic load(input logic [ADDR_W-1:0] a, input logic rd, output int lc);
      logic ok;
      addr_o <= a;
      load_n_o <= 1'b0;
      rw_o <= rd;
      ok = 1'b0;
      while (ok !== 1'b1) begin
         @(posedge core_clk_i);
         ok = cmd_ready_i;
      end
      lc = cyc;
      {addr_o, load_n_o, rw_o} <= {~a, 1'b1, ~rd};
   endtask
   // write burst: beat0 at the first true edge after the load, beat1 at the next edge
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [35:0] d0, d1, input logic [1:0] b0, b1);
      int lc;
      load(a, 1'b0, lc);
      @(posedge core_clk_i);
      {d_o, be_n_o} <= {d0, b0};
      @(posedge core_clk_i);
      {d_o, be_n_o} <= {d1, b1};
      @(posedge core_clk_i);
      {d_o, be_n_o} <= {~d1, ~b1};
   endtask
   // read burst; the receiver stalls for the first stall cycles, so a stall of 5 or more fills the buffer
   task automatic rd(input logic [ADDR_W-1:0] a, input int stall, output logic [35:0] q0, q1,
                     output int rv, oe);
      int lc;
      int n;
      logic tk;
      load(a, 1'b1, lc);
      {rv, oe, n} = {-32'sd1, -32'sd1, 32'sd0};
      for (int i = 0; i < 60 && n < 2; i++) begin
         ready_o <= 1'(i >= stall);
         // sampled at the rising edge, with the values that stood before it
         @(posedge core_clk_i);
         if (read_valid_i === 1'b1 && rv < 0) rv = cyc - lc;
         if (q_oe_i[0] === 1'b1 && oe < 0) oe = cyc - lc;
         tk = q_oe_i[0] & ready_o;
         if (tk === 1'b1 && n == 0) q0 = q_i;
         else if (tk === 1'b1) q1 = q_i;
         n += (tk === 1'b1);
      end
      ready_o <= 1'b1;
   endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the sram bus port and its apb control
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ddrsp_pkg::*;
   logic core_clk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [APB_AW-1:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [ADDR_W-1:0] addr;
   logic load_n, rw, ready, cmd_ready, rvalid, echo, echo_n, term_range_sel, term, minz, pllb, echo_q;
   logic [BE_W-1:0] be_n;
   logic [BUS_W-1:0] dw, dr, oe;
   logic [DATA_W-1:0] mem [logic [MEM_AW-1:0]];
   int failures = 0, tests_run = 0, up = 0;
   ddrsp_port u_ddrsp_port (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .addr_in_i(addr), .cycle_load_n_i(load_n), .rw_sel_i(rw),
      .byte_write_en_n_i(be_n), .dq_i(dw), .dq_o(dr), .dq_oe_o(oe), .dq_ready_i(ready),
      .cmd_ready_o(cmd_ready), .read_valid_out_o(rvalid), .echo_clk_o(echo), .echo_clk_n_o(echo_n),
      .odt_en_o(term_range_sel), .term_range_o(term), .min_imp_o(minz), .pll_bypass_o(pllb));
   ddrsp_ctl_model u_ddrsp_ctl_model (.core_clk_i(core_clk_i), .cmd_ready_i(cmd_ready), .q_i(dr),
      .q_oe_i(oe), .read_valid_i(rvalid), .addr_o(addr), .load_n_o(load_n), .rw_o(rw), .be_n_o(be_n),
      .d_o(dw), .ready_o(ready));
   // 200 MHz core clock; its cycles alternate as true and complement half periods, never idle
   always #(CLK_PERIOD_NS / 2.0) core_clk_i = ~core_clk_i;
   task automatic check(input string what, input logic [35:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // one apb transfer; waits for pready at rising edges, never assumes a wait count;
   // one idle edge after it so the next setup never re-drives psel in the same step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      logic ok;
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
      @(posedge core_clk_i);
      penable <= 1'b1;
      ok = 1'b0;
      while (ok !== 1'b1) begin
         @(posedge core_clk_i);
         {ok, rd, err} = {pready, prdata, pslverr};
      end
      {psel, penable} <= 2'b00;
      @(posedge core_clk_i);
   endtask
   // expected word after a masked write: enable low stores the byte
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n, input logic [1:0] bn);
      return {bn[1] ? o[17:9] : n[17:9], bn[0] ? o[8:0] : n[8:0]};
   endfunction
   // free-running echo clocks and termination, checked each half period once settled
   always @(negedge core_clk_i) if (rst_n_i) begin
      up++;
      if (up > 3) check("echo toggle", {35'h0, ~echo_q}, {35'h0, echo});
      check("echo pair", {35'h0, ~echo}, {35'h0, echo_n});
      check("odt", {35'h0, ~oe[0]}, {35'h0, term_range_sel});
      check("upper oe", 36'h0, {18'h0, oe[35:18]});
      echo_q = echo;
   end
   initial begin
      #100000;
      failures++;
      $display("unexpected watchdog: expected end of tests, seen hang");
      conclude();
   end
   initial begin
      logic [31:0] r;
      logic e;
      logic [35:0] q0, q1, d0, d1;
      logic [1:0] b0, b1;
      logic [9:0] a;
      int rv, ol;
      void'($urandom(17));
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      apb(1'b0, OFF_CTRL, 32'h0, r, e);
      @(negedge core_clk_i);
      check("ctrl reset", 36'(CTRL_RST), {4'h0, r});
      check("reset pins", 36'h2, {33'h0, pllb, term, minz});
      @(posedge core_clk_i);
      apb(1'b1, OFF_CTRL, 32'h0000_0004, r, e);
      @(negedge core_clk_i);
      check("low range pins", 36'h5, {33'h0, pllb, term, minz});
      @(posedge core_clk_i);
      apb(1'b0, OFF_STAT, 32'h0, r, e);
      check("idle stat", 36'h8, {3'h0, e, r});
      apb(1'b1, OFF_STAT, 32'hFFFF_FFFF, r, e);
      check("stat write err", 36'h1, {35'h0, e});
      apb(1'b0, 12'h010, 32'h0, r, e);
      check("unmapped read", 36'h1_0000_0000, {3'h0, e, r});
      apb(1'b1, OFF_CTRL, 32'h0000_0003, r, e);
      // full bursts at addresses 0, 341, 682 and 1023, then random masked writes and stalled reads
      for (int i = 0; i < 4; i++) begin
         {a, d0, d1} = {10'(341 * i), 36'({$urandom, $urandom}), 36'({$urandom, $urandom})};
         u_ddrsp_ctl_model.wr(a, d0, d1, 2'h0, 2'h0);
         {mem[{a, 1'b0}], mem[{a, 1'b1}]} = {d0[17:0], d1[17:0]};
      end
      for (int i = 0; i < 40; i++) begin
         {a, d0, d1} = {10'(341 * $urandom_range(3)), 36'({$urandom, $urandom}), 36'({$urandom, $urandom})};
         {b0, b1} = 4'($urandom);
         if ($urandom_range(1) == 1) begin
            u_ddrsp_ctl_model.wr(a, d0, d1, b0, b1);
            mem[{a, 1'b0}] = merge(mem[{a, 1'b0}], d0[17:0], b0);
            mem[{a, 1'b1}] = merge(mem[{a, 1'b1}], d1[17:0], b1);
         end else begin
            u_ddrsp_ctl_model.rd(a, (i % 5 == 0) ? 8 : $urandom_range(3), q0, q1, rv, ol);
            check("read beat0", {18'h0, mem[{a, 1'b0}]}, q0);
            check("read beat1", {18'h0, mem[{a, 1'b1}]}, q1);
            check("valid lead", 36'(RD_LAT_HALF - 1), 36'(rv));
            check("read latency", 36'(RD_LAT_HALF), 36'(ol));
         end
      end
      conclude();
   end
endmodule
`default_nettype wire
